// ### hw/gpio_port_regs.svh
// register offsets, field positions and reset values of the gpio port
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

`define OFS_PIN_LEVELS 12'h000
`define OFS_OUTPUT_LATCH 12'h004
`define OFS_DIRECTION 12'h008
`define OFS_PORT_G 12'h00C
`define OFS_SEG_ENABLE0 12'h010
`define PORT_D_PULLUP_BIT 7
`define RST_LATCH 8'h00
`define RST_DIRECTION 8'hFF
`define RST_PORT_G 8'h00
`define RST_SEG_ENABLE 8'h00

`endif

// ### hw/gpio_port_pkg.sv
// types shared by the gpio port design
package gpio_port_pkg;
    typedef enum logic [2:0] {
        SEL_PIN = 3'h0,
        SEL_LATCH = 3'h1,
        SEL_DIR = 3'h2,
        SEL_PORT_G = 3'h3,
        SEL_SEG = 3'h4,
        SEL_NONE = 3'h7
    } reg_sel_t;
endpackage

// ### hw/gpio_port.sv
// eight pin gpio port shared with lcd segment drivers, apb register access
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_regs.svh"

// Operation
// - eight bidirectional pins, one bit each
// - separate direction and output latch registers
// - direction one input, zero drives latch
// - every reset makes all pins inputs
// - shared pull-up enable at bit seven
// - output pins never get a pull-up
// - pull-ups off after reset until enabled
// - port works only while segment disabled
// - segment enable bit n owns pin n
// - enabled segment overrides direction and functions
module gpio_port (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [7:0] i_pin,
    output logic [7:0] o_pin,
    output logic [7:0] o_pin_oe,
    output logic [7:0] o_pullup_en,
    output logic [7:0] o_segment_enable,
    output logic [6:0] o_port_g_ctrl
);

    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic [7:0] dir_q;
    logic [7:0] dir_d;
    logic [7:0] port_g_q;
    logic [7:0] port_g_d;
    logic [7:0] seg_q;
    logic [7:0] seg_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [7:0] pin_q;
    logic [7:0] pin_d;
    logic [7:0] oe_q;
    logic [7:0] oe_d;
    logic [7:0] pu_q;
    logic [7:0] pu_d;
    gpio_port_pkg::reg_sel_t sel;
    logic setup;
    logic access;
    logic wr_en;
    logic [7:0] rd_byte;

    // pads are asynchronous to the core clock
    always_ff @(posedge i_clk)
    begin
        pin_meta_q <= i_pin;
        pin_sync_q <= pin_meta_q;
    end

    always_comb
    begin
        case (i_paddr)
            `OFS_PIN_LEVELS: sel = gpio_port_pkg::SEL_PIN;
            `OFS_OUTPUT_LATCH: sel = gpio_port_pkg::SEL_LATCH;
            `OFS_DIRECTION: sel = gpio_port_pkg::SEL_DIR;
            `OFS_PORT_G: sel = gpio_port_pkg::SEL_PORT_G;
            `OFS_SEG_ENABLE0: sel = gpio_port_pkg::SEL_SEG;
            default: sel = gpio_port_pkg::SEL_NONE;
        endcase
    end

    // no wait states: ready is registered from setup, so it answers in the first access cycle
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable && pready_q;
    // writes land only at the edge that completes the access
    assign wr_en = access && i_pwrite;

    // register file
    always_comb
    begin
        latch_d = latch_q;
        dir_d = dir_q;
        port_g_d = port_g_q;
        seg_d = seg_q;
        if (wr_en)
        begin
            case (sel)
                gpio_port_pkg::SEL_PIN: latch_d = i_pwdata[7:0];
                gpio_port_pkg::SEL_LATCH: latch_d = i_pwdata[7:0];
                gpio_port_pkg::SEL_DIR: dir_d = i_pwdata[7:0];
                gpio_port_pkg::SEL_PORT_G: port_g_d = i_pwdata[7:0];
                gpio_port_pkg::SEL_SEG: seg_d = i_pwdata[7:0];
                // unmapped writes are dropped; the slave error tells software
                default: latch_d = latch_q;
            endcase
        end
    end

    // read mux over the byte-wide registers
    always_comb
    begin
        rd_byte = 8'h00;
        case (sel)
            gpio_port_pkg::SEL_PIN: rd_byte = pin_sync_q;
            gpio_port_pkg::SEL_LATCH: rd_byte = latch_q;
            gpio_port_pkg::SEL_DIR: rd_byte = dir_q;
            gpio_port_pkg::SEL_PORT_G: rd_byte = port_g_q;
            gpio_port_pkg::SEL_SEG: rd_byte = seg_q;
            default: rd_byte = 8'h00;
        endcase
    end

    // bus response; read data frozen at setup so a pad edge cannot tear it
    always_comb
    begin
        prdata_d = prdata_q;
        pready_d = setup;
        pslverr_d = 1'b0;
        if (setup)
        begin
            pslverr_d = (sel == gpio_port_pkg::SEL_NONE);
            prdata_d = {24'h00_0000, rd_byte};
        end
    end

    // pin drive, per bit: segment wins, then direction
    always_comb
    begin
        for (int n = 0; n < 8; n++)
        begin
            oe_d[n] = !seg_d[n] && !dir_d[n];
            pin_d[n] = oe_d[n] && latch_d[n];
            pu_d[n] = port_g_d[`PORT_D_PULLUP_BIT] && dir_d[n] && !seg_d[n];
        end
    end

    // register file: every reset returns the port to inputs, pull-ups off
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            latch_q <= `RST_LATCH;
            dir_q <= `RST_DIRECTION;
            port_g_q <= `RST_PORT_G;
            seg_q <= `RST_SEG_ENABLE;
        end
        else
        begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            port_g_q <= port_g_d;
            seg_q <= seg_d;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // pad drive registered from the next register values, so it moves
    // at the same edge as the register it follows, with no extra lag
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            pin_q <= 8'h00;
            oe_q <= 8'h00;
            pu_q <= 8'h00;
        end
        else
        begin
            pin_q <= pin_d;
            oe_q <= oe_d;
            pu_q <= pu_d;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_pin = pin_q;
    assign o_pin_oe = oe_q;
    assign o_pullup_en = pu_q;
    assign o_segment_enable = seg_q;
    assign o_port_g_ctrl = port_g_q[6:0];

    // pad side
    AST_OE_FOLLOWS_DIR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_pin_oe == (~dir_q & ~seg_q))
        else $error("pin drive does not follow direction");
    AST_DRIVE_LATCH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (o_pin & ~latch_q) == 8'h00)
        else $error("driven pin differs from latch");
    AST_DRIVE_VALUE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_pin == (latch_q & o_pin_oe))
        else $error("driven value not the latch");
    AST_RESET_INPUTS: assert property (@(posedge i_clk)
        $past(i_sys_rst) |-> (o_pin_oe == 8'h00 && dir_q == 8'hFF))
        else $error("pins not inputs after reset");
    AST_SEG_RESET: assert property (@(posedge i_clk)
        $past(i_sys_rst) |-> o_segment_enable == 8'h00)
        else $error("segment enabled after reset");
    AST_PULLUP_GLOBAL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !port_g_q[`PORT_D_PULLUP_BIT] |-> o_pullup_en == 8'h00)
        else $error("pull-up on while disabled");
    AST_PULLUP_INPUT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        port_g_q[`PORT_D_PULLUP_BIT] |-> o_pullup_en == (dir_q & ~seg_q))
        else $error("pull-up missing on an input pin");
    AST_PULLUP_OUTPUT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (o_pullup_en & o_pin_oe) == 8'h00)
        else $error("pull-up on an output pin");
    AST_PULLUP_RESET: assert property (@(posedge i_clk)
        $past(i_sys_rst) |-> o_pullup_en == 8'h00)
        else $error("pull-up on after reset");
    AST_SEG_OWNS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ((o_segment_enable & (o_pin_oe | o_pullup_en)) == 8'h00))
        else $error("port active on segment pin");
    AST_SEG_IGNORES_DIR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ($changed(dir_q) && $stable(seg_q) && seg_q == 8'hFF) |-> o_pin_oe == 8'h00)
        else $error("direction acted on segment pin");

    // register bus side
    AST_SEG_MAP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        access && i_pwrite && sel == gpio_port_pkg::SEL_SEG
        |=> o_segment_enable == $past(i_pwdata[7:0]))
        else $error("segment enable not written");
    AST_LATCH_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        setup && sel == gpio_port_pkg::SEL_LATCH |=> o_pready && o_prdata[7:0] == latch_q)
        else $error("latch read wrong");
    AST_PIN_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        access && i_pwrite && sel == gpio_port_pkg::SEL_PIN
        |=> latch_q == $past(i_pwdata[7:0]))
        else $error("pin write missed latch");
    AST_PIN_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        setup && sel == gpio_port_pkg::SEL_PIN |=> o_prdata[7:0] == $past(pin_sync_q))
        else $error("pin read not the pad level");
    AST_LATCH_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wr_en && sel == gpio_port_pkg::SEL_LATCH |=> latch_q == $past(i_pwdata[7:0]))
        else $error("latch write lost");
    AST_DIR_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wr_en && sel == gpio_port_pkg::SEL_DIR |=> dir_q == $past(i_pwdata[7:0]))
        else $error("direction write lost");
    AST_DIR_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        setup && sel == gpio_port_pkg::SEL_DIR |=> o_pready && o_prdata[7:0] == dir_q)
        else $error("direction read wrong");
    AST_PORT_G_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wr_en && sel == gpio_port_pkg::SEL_PORT_G |=> port_g_q == $past(i_pwdata[7:0]))
        else $error("shared register write lost");
    AST_PORT_G_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        setup && sel == gpio_port_pkg::SEL_PORT_G |=> o_prdata[7:0] == port_g_q)
        else $error("shared register read wrong");
    AST_SEG_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        setup && sel == gpio_port_pkg::SEL_SEG |=> o_prdata[7:0] == seg_q)
        else $error("segment enable read wrong");
    AST_UNMAPPED_WRITE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wr_en && sel == gpio_port_pkg::SEL_NONE
        |=> $stable(latch_q) && $stable(dir_q) && $stable(port_g_q) && $stable(seg_q))
        else $error("unmapped write changed a register");
    AST_NO_READ_EFFECT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        access && !i_pwrite |=> $stable(latch_q) && $stable(dir_q))
        else $error("read changed a register");
    AST_SLVERR_UNMAPPED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        setup && sel == gpio_port_pkg::SEL_NONE |=> o_pready && o_pslverr)
        else $error("unmapped access not refused");
    AST_SLVERR_WITH_READY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_pslverr |-> o_pready)
        else $error("slave error without ready");
    AST_PREADY_PULSE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    AST_PRDATA_UPPER: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    COV_DRIVE: cover property (@(posedge i_clk) o_pin_oe != 8'h00);
    COV_PULLUP: cover property (@(posedge i_clk) o_pullup_en == 8'hFF);
    COV_SEG: cover property (@(posedge i_clk) o_segment_enable != 8'h00 && dir_q == 8'h00);
    COV_SEG_ALL: cover property (@(posedge i_clk) o_segment_enable == 8'hFF);
    COV_ERR: cover property (@(posedge i_clk) o_pready && o_pslverr);

endmodule
`default_nettype wire

// ### sim/pad_model.sv
// pad model: resolves each pin from device drive, outside drive and pull-up
`timescale 1ns/1ns
`default_nettype none
module pad_model (
    input wire logic i_clk,
    input wire logic [7:0] i_drv,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_pu,
    input wire logic [7:0] i_ext,
    input wire logic [7:0] i_ext_en,
    output logic [7:0] o_level
);
    logic [7:0] float_q = 8'h00;
    // an undriven pad wanders so a stale value never passes
    always @(posedge i_clk)
        float_q <= ~float_q;
    always_comb
        for (int b = 0; b < 8; b++)
            o_level[b] = i_oe[b] ? i_drv[b] : i_ext_en[b] ? i_ext[b] : i_pu[b] | float_q[b];
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the gpio port over apb and its pads
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_regs.svh"
module testbench;
    typedef struct packed {logic [11:0] wa; logic [31:0] w; logic [11:0] ra; logic [7:0] r; logic e;} row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [7:0] pad, drv, oe, pu, seg;
    logic [6:0] ctrl;
    logic [7:0] ext = 8'h3C;
    logic [7:0] ext_en = 8'hFF;
    int errors = 0;
    int samples_checked = 0;
    row_t rows [7] = '{'{`OFS_DIRECTION, 32'hFFFFFFCF, `OFS_DIRECTION, 8'hCF, 1'b0},
        '{`OFS_OUTPUT_LATCH, 32'h5A, `OFS_OUTPUT_LATCH, 8'h5A, 1'b0},
        '{`OFS_PIN_LEVELS, 32'hA5, `OFS_OUTPUT_LATCH, 8'hA5, 1'b0},
        '{`OFS_PORT_G, 32'h80, `OFS_PORT_G, 8'h80, 1'b0},
        '{`OFS_SEG_ENABLE0, 32'h81, `OFS_SEG_ENABLE0, 8'h81, 1'b0},
        '{`OFS_SEG_ENABLE0, 32'h00, `OFS_SEG_ENABLE0, 8'h00, 1'b0},
        '{12'h014, 32'hFF, 12'h014, 8'h00, 1'b1}};
    gpio_port DUT (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_pin(pad), .o_pin(drv), .o_pin_oe(oe),
        .o_pullup_en(pu), .o_segment_enable(seg), .o_port_g_ctrl(ctrl));
    pad_model pads (.i_clk(clk), .i_drv(drv), .i_oe(oe), .i_pu(pu), .i_ext(ext),
        .i_ext_en(ext_en), .o_level(pad));
    always #10 clk = ~clk;
    task automatic stop_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            stop_test();
        end
        @(posedge clk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(oe, 8'h00);
        chk(pu, 8'h00);
        apb(`OFS_DIRECTION, 1'b0, 32'h0);
        chk(rd[7:0], 8'hFF);
    endtask
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            apb(rows[i].wa, 1'b1, rows[i].w);
            apb(rows[i].ra, 1'b0, 32'h0);
            chk(rd[7:0], rows[i].r);
            chk({7'h00, err}, {7'h00, rows[i].e});
        end
        chk(oe, 8'h30);
        chk(drv, 8'h20);
        chk(pu, 8'hCF);
        apb(`OFS_PIN_LEVELS, 1'b0, 32'h0);
        chk(rd[7:0], 8'h2C);
        apb(`OFS_SEG_ENABLE0, 1'b1, 32'h31);
        chk(seg, 8'h31);
        chk(oe, 8'h00);
        chk(pu, 8'hCE);
        apb(`OFS_SEG_ENABLE0, 1'b1, 32'hFF);
        apb(`OFS_DIRECTION, 1'b1, 32'h00);
        chk(oe, 8'h00);
        chk(drv, 8'h00);
        chk(pu, 8'h00);
        apb(`OFS_SEG_ENABLE0, 1'b1, 32'h00);
        chk(oe, 8'hFF);
        chk(drv, 8'hA5);
        chk(pu, 8'h00);
        // pad level reaches the read path two edges later
        repeat (2) @(posedge clk);
        apb(`OFS_PIN_LEVELS, 1'b0, 32'h0);
        chk(rd[7:0], 8'hA5);
        do_reset();
        apb(`OFS_PORT_G, 1'b1, 32'hFF);
        chk(pu, 8'hFF);
        chk({1'b0, ctrl}, 8'h7F);
        ext_en <= 8'h00;
        repeat (4) @(posedge clk);
        apb(`OFS_PIN_LEVELS, 1'b0, 32'h0);
        chk(rd[7:0], 8'hFF);
        apb(`OFS_PORT_G, 1'b1, 32'h00);
        chk(pu, 8'h00);
        chk({1'b0, ctrl}, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
